//--- include/pmc_pkg.sv
// Constants, register map and state encoding of the power control sequencer.
package pmc_pkg;

  // Power control states.
  typedef enum logic [3:0] {
    PMC_OFF,
    PMC_COLD,
    PMC_WDOG,
    PMC_ON,
    PMC_UOWAIT,
    PMC_MEMORY_HOLD_STATE,
    PMC_USER_OFF_STATE,
    PMC_WARM,
    PMC_POWER_CUT
  } pmc_state_type;

  // Clock rates and the fixed initialisation window of both start states.
  localparam int SYS_HZ      = 200_000_000;
  localparam int SLOW_HZ     = 32_768;
  localparam int INIT_US     = 8000;
  localparam int TICK_DIV    = SYS_HZ / SLOW_HZ;
  localparam int INIT_TICKS  = (INIT_US * SLOW_HZ + 999_999) / 1_000_000;

  // APB register byte offsets.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_BUCK   = 8'h04;
  localparam logic [7:0] REG_POWER_CUT   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;

  // Control register fields.
  localparam int CTRL_USER_OFF_REQ  = 0;
  localparam int CTRL_WARM_EN       = 1;
  localparam int CTRL_RESTART_COLD  = 2;
  localparam int CTRL_POWER_CUT_EN       = 3;
  localparam int CTRL_POWER_CUT_CNT_EN   = 4;
  localparam int CTRL_CPU_CLK_EN    = 5;
  localparam int CTRL_UO_CLK_KEEP   = 6;
  localparam int CTRL_CLK_KEEP_MODE = 7;
  localparam int CTRL_SURVIVED      = 8;
  localparam int CTRL_WIDTH         = 8;
  localparam logic [7:0] CTRL_DEFAULT = 8'h00;

  // Buck mode register fields.
  localparam int BUCK_MH_LSB = 0;
  localparam int BUCK_UO_LSB = 8;

  // Power-cut register fields.
  localparam int POWER_CUT_DUR_LSB = 0;
  localparam int POWER_CUT_LIM_LSB = 8;
  localparam int POWER_CUT_CNT_LSB = 12;
  localparam logic [7:0] POWER_CUT_DUR_DEFAULT = 8'h00;
  localparam logic [3:0] POWER_CUT_LIM_DEFAULT = 4'hF;

  // Status register fields; flags are write-one-to-clear.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MH_WAKE   = 8;
  localparam int STAT_WARM      = 9;
  localparam int STAT_POWER_CUT      = 10;

endpackage : pmc_pkg

//--- hdl/pmc_sync.sv
// Two-flop synchroniser for pins and comparator levels.
`timescale 1ns/1ps
module pmc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : pmc_sync

//--- hdl/pmc_power_ctrl.sv
// Power control state machine with power-cut handling and APB registers.
//
// Summary of operation
// - Watchdog state: timer runs, resets high, then On.
// - Watchdog ignores keep-alive and standby inputs.
// - Keep-alive low in On: off or cold.
// - User-off request enters wait; keep-alive ignored.
// - Wait expiry: user off if warm, else hold.
// - Wait end drops system reset, clears request.
// - Memory hold: resets low, peripheral clock off, cpu clock off unless keep.
// - Memory hold buck follows its hold mode bit.
// - Turn-on in hold: cold, defaults, wake flag.
// - Hold-kept bucks stay on through cold boot.
// - User off: system reset low, cpu reset high.
// - User off buck stays on when mode set.
// - Turn-on in user off: warm start, defaults.
// - Warm start: 8 ms init, kept bucks stay.
// - Warm reset timer, then watchdog, flag, release.
// - Power cut: all off, resets low, bus refused.
// - Enabled power cut on undervoltage starts timer.
// - Duration field constant; separate countdown counter.
// - Cut expiry: off, clear survived, shutdown pulse.
// - Supply back above thresholds: cold after timer.
// - Count cuts; at limit cut ends off.
// - Power cut disabled: supply failure goes off.
// - Survived flag rtc reset; cut flag cleared.
// - Cold start holds resets, then watchdog.
// - Bus only in watchdog, on, wait; interrupt gated.
`timescale 1ns/1ps
module pmc_power_ctrl
  import pmc_pkg::*;
#(
  parameter int TICK_CYCLES  = pmc_pkg::TICK_DIV,
  parameter int WDOG_TICKS   = 128,
  parameter int WAIT_TICKS   = 256,
  parameter int RESET_TICKS  = 640,
  parameter int UV_TICKS     = 64,
  parameter int POWER_CUT_UNIT    = 32,
  parameter int SLOT_TICKS   = 16,
  parameter int N_BUCK       = 5
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              keepalive_in,
  input  wire logic              turn_on_event,
  input  wire logic              supply_above_uv,
  input  wire logic              supply_above_low_battery_level,
  output logic                   system_reset_n,
  output logic                   cpu_reset_n,
  output logic                   periph_slow_clk_out,
  output logic                   cpu_slow_clk_out,
  output logic      [N_BUCK-1:0] buck_enable,
  output logic                   shutdown_pulse_n,
  output logic                   int_out
);

  pmc_state_type    state;
  pmc_state_type    next_state;
  logic [15:0]      div_cnt;
  logic             tick;
  logic             slow_phase;
  logic [15:0]      state_time;
  logic [2:0]       pins;
  logic             keepalive_s;
  logic             turn_on_s;
  logic             above_uv_s;
  logic             above_low_battery_level_s;
  logic [CTRL_WIDTH:0] ctrl;
  logic [N_BUCK-1:0] mh_mode;
  logic [N_BUCK-1:0] uo_mode;
  logic [N_BUCK-1:0] keep_mask;
  logic [7:0]       power_cut_duration;
  logic [3:0]       power_cut_count_limit;
  logic [3:0]       power_cut_count;
  logic [7:0]       power_cut_left;
  logic             power_cut_doomed;
  logic             uv_seen;
  logic [15:0]      uv_time;
  logic             memory_hold_wake_irq;
  logic             warm_start_irq;
  logic             power_cut_irq;
  logic             bus_open;
  logic             acc;
  logic             mapped;
  logic             wr;
  logic             load_defaults;
  logic             supply_fail;
  logic             power_cut_expired;
  logic             power_cut_recovered;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation and the 32 kHz time base.

  pmc_sync #(
    .WIDTH (3)
  ) u_sync_pins (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in ({keepalive_in, turn_on_event, supply_above_low_battery_level}),
    .sync_out (pins)
  );

  pmc_sync #(
    .WIDTH (1)
  ) u_sync_uv (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in (supply_above_uv),
    .sync_out (above_uv_s)
  );

  assign keepalive_s    = pins[2];
  assign turn_on_s      = pins[1];
  assign above_low_battery_level_s = pins[0];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt    <= '0;
      slow_phase <= 1'b0;
    end else begin
      if (tick) begin
        div_cnt <= '0;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
      if (tick || div_cnt == 16'((TICK_CYCLES - 1) / 2)) begin
        slow_phase <= ~slow_phase;
      end
    end
  end

  assign tick = (div_cnt == 16'(TICK_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // State machine.

  assign supply_fail    = !above_uv_s;
  assign power_cut_expired   = (power_cut_left == 8'h00) && tick && state_time == 16'(POWER_CUT_UNIT - 1);
  assign power_cut_recovered = uv_seen && above_low_battery_level_s && uv_time >= 16'(UV_TICKS);

  always_comb begin
    next_state = state;
    case (state)
      PMC_OFF: begin
        if (turn_on_s && above_uv_s) begin
          next_state = PMC_COLD;
        end
      end
      PMC_COLD: begin
        if (tick && state_time == 16'(RESET_TICKS - 1)) begin
          next_state = PMC_WDOG;
        end
      end
      PMC_WDOG: begin
        // Keep-alive is not examined here until the timer runs out.
        if (tick && state_time == 16'(WDOG_TICKS - 1)) begin
          next_state = PMC_ON;
        end
      end
      PMC_ON: begin
        if (ctrl[CTRL_USER_OFF_REQ]) begin
          next_state = PMC_UOWAIT;
        end else if (!keepalive_s) begin
          next_state = ctrl[CTRL_RESTART_COLD] ? PMC_COLD : PMC_OFF;
        end
      end
      PMC_UOWAIT: begin
        if (tick && state_time == 16'(WAIT_TICKS - 1)) begin
          next_state = ctrl[CTRL_WARM_EN] ? PMC_USER_OFF_STATE : PMC_MEMORY_HOLD_STATE;
        end
      end
      PMC_MEMORY_HOLD_STATE: begin
        if (turn_on_s) begin
          next_state = PMC_COLD;
        end
      end
      PMC_USER_OFF_STATE: begin
        if (turn_on_s) begin
          next_state = PMC_WARM;
        end
      end
      PMC_WARM: begin
        if (tick && state_time == 16'(RESET_TICKS - 1)) begin
          next_state = PMC_WDOG;
        end
      end
      PMC_POWER_CUT: begin
        if (power_cut_expired) begin
          next_state = PMC_OFF;
        end else if (power_cut_recovered && !power_cut_doomed) begin
          next_state = PMC_COLD;
        end
      end
      default: begin
        next_state = PMC_OFF;
      end
    endcase
    // Supply loss overrides every powered state.
    if (supply_fail && state != PMC_OFF && state != PMC_POWER_CUT) begin
      next_state = ctrl[CTRL_POWER_CUT_EN] ? PMC_POWER_CUT : PMC_OFF;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state      <= PMC_OFF;
      state_time <= '0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        state_time <= '0;
      end else if (tick) begin
        if (state == PMC_POWER_CUT && state_time == 16'(POWER_CUT_UNIT - 1)) begin
          state_time <= '0;
        end else if (state_time != 16'hFFFF) begin
          state_time <= state_time + 16'h0001;
        end
      end
    end
  end

  assign load_defaults = (state == PMC_MEMORY_HOLD_STATE || state == PMC_USER_OFF_STATE) && turn_on_s;

  ////////////////////////////////////////////////////////////////////////////
  // Power-cut countdown, recovery timing and entry counting.

  // The countdown is its own counter so the programmed duration never changes.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      power_cut_left   <= '0;
      power_cut_doomed <= 1'b0;
      uv_seen     <= 1'b0;
      uv_time     <= '0;
    end else begin
      if (next_state == PMC_POWER_CUT && state != PMC_POWER_CUT) begin
        power_cut_left   <= power_cut_duration;
        power_cut_doomed <= ctrl[CTRL_POWER_CUT_CNT_EN] &&
                       power_cut_count == power_cut_count_limit;
        uv_seen     <= 1'b0;
        uv_time     <= '0;
      end else if (state == PMC_POWER_CUT) begin
        if (tick && state_time == 16'(POWER_CUT_UNIT - 1) && power_cut_left != 8'h00) begin
          power_cut_left <= power_cut_left - 8'h01;
        end
        if (above_uv_s) begin
          uv_seen <= 1'b1;
        end
        if (!uv_seen) begin
          uv_time <= '0;
        end else if (tick && uv_time != 16'hFFFF) begin
          uv_time <= uv_time + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave; refused while the machine sits outside the three open states.

  assign bus_open = (state == PMC_WDOG || state == PMC_ON || state == PMC_UOWAIT);
  assign acc      = psel && penable;
  assign pready   = 1'b1;
  always_comb begin
    if (paddr == REG_CTRL || paddr == REG_BUCK) begin
      mapped = 1'b1;
    end else if (paddr == REG_POWER_CUT || paddr == REG_STATUS) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end
  assign pslverr = acc && (!bus_open || !mapped);
  assign wr      = acc && pwrite && bus_open && mapped;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= '0;
      if (!bus_open) begin
        prdata <= '0;
      end else if (paddr == REG_CTRL) begin
        prdata[CTRL_WIDTH:0] <= ctrl;
      end else if (paddr == REG_BUCK) begin
        prdata[BUCK_MH_LSB +: N_BUCK] <= mh_mode;
        prdata[BUCK_UO_LSB +: N_BUCK] <= uo_mode;
      end else if (paddr == REG_POWER_CUT) begin
        prdata[POWER_CUT_DUR_LSB +: 8] <= power_cut_duration;
        prdata[POWER_CUT_LIM_LSB +: 4] <= power_cut_count_limit;
        prdata[POWER_CUT_CNT_LSB +: 4] <= power_cut_count;
      end else if (paddr == REG_STATUS) begin
        prdata[STAT_STATE_LSB +: 4] <= state;
        prdata[STAT_MH_WAKE]        <= memory_hold_wake_irq;
        prdata[STAT_WARM]           <= warm_start_irq;
        prdata[STAT_POWER_CUT]           <= power_cut_irq;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  // Control bits return to defaults on wake from the low-power off states;
  // the survived flag and power-cut settings are coin-cell backed and stay.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= {1'b0, CTRL_DEFAULT};
    end else begin
      if (load_defaults) begin
        ctrl[CTRL_WIDTH-1:0] <= CTRL_DEFAULT;
      end else if (wr && paddr == REG_CTRL) begin
        ctrl[CTRL_WIDTH-1:0] <= pwdata[CTRL_WIDTH-1:0];
      end
      if (wr && paddr == REG_CTRL) begin
        ctrl[CTRL_SURVIVED] <= pwdata[CTRL_SURVIVED];
      end
      if (!system_reset_n) begin
        ctrl[CTRL_USER_OFF_REQ] <= 1'b0;
      end
      if (state == PMC_POWER_CUT && next_state == PMC_OFF) begin
        ctrl[CTRL_SURVIVED] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mh_mode <= '0;
      uo_mode <= '0;
    end else if (load_defaults) begin
      mh_mode <= '0;
      uo_mode <= '0;
    end else if (wr && paddr == REG_BUCK) begin
      mh_mode <= pwdata[BUCK_MH_LSB +: N_BUCK];
      uo_mode <= pwdata[BUCK_UO_LSB +: N_BUCK];
    end
  end

  // A write in the power-cut entry cycle takes priority over the count increment.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      power_cut_duration    <= POWER_CUT_DUR_DEFAULT;
      power_cut_count_limit <= POWER_CUT_LIM_DEFAULT;
      power_cut_count       <= '0;
    end else begin
      if (wr && paddr == REG_POWER_CUT) begin
        power_cut_duration    <= pwdata[POWER_CUT_DUR_LSB +: 8];
        power_cut_count_limit <= pwdata[POWER_CUT_LIM_LSB +: 4];
        power_cut_count       <= pwdata[POWER_CUT_CNT_LSB +: 4];
      end else if (next_state == PMC_POWER_CUT && state != PMC_POWER_CUT &&
                   ctrl[CTRL_POWER_CUT_CNT_EN] && power_cut_count != power_cut_count_limit) begin
        power_cut_count <= power_cut_count + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags; a set in the same cycle as a clear wins.

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      memory_hold_wake_irq <= 1'b0;
      warm_start_irq       <= 1'b0;
      power_cut_irq        <= 1'b0;
    end else begin
      if (wr && paddr == REG_STATUS) begin
        memory_hold_wake_irq <= memory_hold_wake_irq & ~pwdata[STAT_MH_WAKE];
        warm_start_irq       <= warm_start_irq & ~pwdata[STAT_WARM];
        power_cut_irq        <= power_cut_irq & ~pwdata[STAT_POWER_CUT];
      end
      if (state == PMC_OFF) begin
        power_cut_irq <= 1'b0;
      end
      if (state == PMC_MEMORY_HOLD_STATE && next_state == PMC_COLD) begin
        memory_hold_wake_irq <= 1'b1;
      end
      if (state == PMC_WARM && next_state == PMC_WDOG) begin
        warm_start_irq <= 1'b1;
      end
      if (state != PMC_POWER_CUT && next_state == PMC_POWER_CUT) begin
        power_cut_irq <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: resets, slow clocks, shutdown pulse, buck enables.

  // Bucks kept by the mode bits of the low-power state just left.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      keep_mask <= '0;
    end else if (state == PMC_MEMORY_HOLD_STATE && next_state == PMC_COLD) begin
      keep_mask <= mh_mode;
    end else if (state == PMC_USER_OFF_STATE && next_state == PMC_WARM) begin
      keep_mask <= uo_mode;
    end else if (next_state == PMC_COLD && state != PMC_COLD) begin
      keep_mask <= '0;
    end
  end

  // After the init window the bucks come up one slot apart to spread inrush.
  // Kept bucks read the mode bits on the entry edge, so they never dip for a cycle.
  generate
    for (genvar b = 0; b < N_BUCK; b++) begin : g_buck
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          buck_enable[b] <= 1'b0;
        end else begin
          case (next_state)
            PMC_COLD, PMC_WARM: begin
              buck_enable[b] <= (state == PMC_MEMORY_HOLD_STATE && mh_mode[b]) ||
                                (state == PMC_USER_OFF_STATE && uo_mode[b]) ||
                                (state == next_state && (keep_mask[b] ||
                                 state_time >= 16'(INIT_TICKS + b * SLOT_TICKS)));
            end
            PMC_WDOG, PMC_ON, PMC_UOWAIT: buck_enable[b] <= 1'b1;
            PMC_MEMORY_HOLD_STATE: buck_enable[b] <= mh_mode[b];
            PMC_USER_OFF_STATE: buck_enable[b] <= uo_mode[b];
            default: buck_enable[b] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      system_reset_n      <= 1'b0;
      cpu_reset_n         <= 1'b0;
      periph_slow_clk_out <= 1'b0;
      cpu_slow_clk_out    <= 1'b0;
      shutdown_pulse_n    <= 1'b1;
      int_out             <= 1'b0;
    end else begin
      system_reset_n   <= (next_state == PMC_WDOG || next_state == PMC_ON ||
                           next_state == PMC_UOWAIT);
      cpu_reset_n      <= (next_state == PMC_WDOG || next_state == PMC_ON ||
                           next_state == PMC_UOWAIT || next_state == PMC_USER_OFF_STATE ||
                           next_state == PMC_WARM);
      periph_slow_clk_out <= slow_phase && (next_state == PMC_WDOG ||
                             next_state == PMC_ON || next_state == PMC_UOWAIT);
      case (next_state)
        PMC_WDOG, PMC_ON, PMC_UOWAIT: cpu_slow_clk_out <= slow_phase;
        PMC_MEMORY_HOLD_STATE: cpu_slow_clk_out <= slow_phase && ctrl[CTRL_CLK_KEEP_MODE];
        PMC_USER_OFF_STATE: cpu_slow_clk_out <= slow_phase &&
          ((ctrl[CTRL_CPU_CLK_EN] && ctrl[CTRL_UO_CLK_KEEP]) || ctrl[CTRL_CLK_KEEP_MODE]);
        PMC_WARM: cpu_slow_clk_out <= slow_phase &&
          (ctrl[CTRL_CPU_CLK_EN] || ctrl[CTRL_CLK_KEEP_MODE]);
        default: cpu_slow_clk_out <= 1'b0;
      endcase
      // The pulse lasts one slow tick and is released by the next tick.
      if (state == PMC_POWER_CUT && next_state == PMC_OFF) begin
        shutdown_pulse_n <= 1'b0;
      end else if (tick) begin
        shutdown_pulse_n <= 1'b1;
      end
      int_out <= (next_state == PMC_WDOG || next_state == PMC_ON) &&
                 (memory_hold_wake_irq || warm_start_irq || power_cut_irq);
    end
  end

endmodule : pmc_power_ctrl

//--- bench/pmc_checker.sv
// Checker of reset, bus and shutdown relations at the sequencer ports.
`timescale 1ns/1ps
module pmc_checker #(
  parameter int TICK_CYCLES = 4,
  parameter int N_BUCK      = 5
) (
  input wire logic              clk_sys,
  input wire logic              rst_b,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pslverr,
  input wire logic              supply_above_uv,
  input wire logic              system_reset_n,
  input wire logic              cpu_reset_n,
  input wire logic              periph_slow_clk_out,
  input wire logic              cpu_slow_clk_out,
  input wire logic [N_BUCK-1:0] buck_enable,
  input wire logic              shutdown_pulse_n,
  input wire logic              int_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // Everything powered down: no buck, processor in reset, no clock out.
  wire quiet = !(|buck_enable) && !cpu_reset_n && !periph_slow_clk_out && !cpu_slow_clk_out;
  int low_cnt;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) low_cnt <= 0;
    else if (!shutdown_pulse_n) low_cnt <= low_cnt + 1;
    else low_cnt <= 0;
  end
  ////////////////////////////////////////
  AST_BUS_REFUSED: assert property (psel && penable && !system_reset_n |-> pslverr)
    else $error("bus open while system held in reset");
  AST_INT_GATED: assert property (!system_reset_n |-> !int_out)
    else $error("interrupt line high in a held state");
  AST_RESET_PAIR: assert property (!cpu_reset_n |-> !system_reset_n)
    else $error("cpu reset low while system reset high");
  AST_COLD_RELEASE: assert property ($rose(cpu_reset_n) |-> system_reset_n)
    else $error("cpu reset released alone");
  AST_WARM_RELEASE: assert property ($rose(system_reset_n) |-> cpu_reset_n)
    else $error("system reset released under cpu reset");
  AST_SUPPLY_LOSS: assert property (!supply_above_uv [*4] |-> quiet)
    else $error("outputs alive after supply loss");
  AST_SDWN_STATE: assert property (!shutdown_pulse_n |-> quiet)
    else $error("shutdown pulse while powered");
  AST_SDWN_LEN: assert property ($rose(shutdown_pulse_n) |-> low_cnt == TICK_CYCLES)
    else $error("shutdown pulse not one slow tick long");
endmodule : pmc_checker

bind pmc_power_ctrl pmc_checker #(.TICK_CYCLES(TICK_CYCLES), .N_BUCK(N_BUCK)) i_pmc_checker (
  .clk_sys, .rst_b, .psel, .penable, .pslverr, .supply_above_uv, .system_reset_n,
  .cpu_reset_n, .periph_slow_clk_out, .cpu_slow_clk_out, .buck_enable, .shutdown_pulse_n,
  .int_out
);

//--- bench/pmc_cpu_model.sv
// Application processor model driving the keep-alive pin.
`timescale 1ns/1ps
module pmc_cpu_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cpu_reset_n,
  input wire logic alive,
  output logic     keepalive_in
);
  // A processor held in reset cannot toggle its pin, so keep-alive drops with its reset.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) keepalive_in <= 1'b0;
    else keepalive_in <= alive && cpu_reset_n;
  end
endmodule : pmc_cpu_model

//--- bench/tb.sv
// Self-checking bench of the power control sequencer.
`timescale 1ns/1ps
module tb;
  import pmc_pkg::*;
  logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, alive = 0;
  logic turn_on_event = 0, supply_above_uv = 1, supply_above_low_battery_level = 1, sd_seen = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, err, keepalive_in, system_reset_n, cpu_reset_n, po, co;
  logic periph_slow_clk_out, cpu_slow_clk_out, shutdown_pulse_n, int_out;
  logic [4:0] buck_enable;
  int mismatches = 0, samples_checked = 0, cyc = 0;
  pmc_power_ctrl #(.TICK_CYCLES(4), .WDOG_TICKS(16), .RESET_TICKS(8), .UV_TICKS(2),
    .POWER_CUT_UNIT(2)) i_pmc_power_ctrl (
    .clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .keepalive_in, .turn_on_event, .supply_above_uv, .supply_above_low_battery_level, .system_reset_n,
    .cpu_reset_n, .periph_slow_clk_out, .cpu_slow_clk_out, .buck_enable, .shutdown_pulse_n,
    .int_out);
  pmc_cpu_model i_pmc_cpu_model (.clk_sys, .rst_b, .cpu_reset_n, .alive, .keepalive_in);
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (!shutdown_pulse_n) sd_seen <= 1'b1;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  ////////////////////////////////////////
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task rd_state(input pmc_state_type s);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rdat[3:0], s);
    chk(err, 1'b0);
  endtask : rd_state
  task wait_sys(input logic v);
    int n;
    n = 0;
    while (system_reset_n !== v && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(system_reset_n, v);
  endtask : wait_sys
  task clk_scan;
    po = 0; co = 0;
    repeat (16) begin
      @(posedge clk_sys);
      po = po | periph_slow_clk_out;
      co = co | cpu_slow_clk_out;
    end
  endtask : clk_scan
  // Supply dips, then climbs past the undervoltage level before the low-battery level.
  task dip;
    @(posedge clk_sys);
    sd_seen <= 1'b0; supply_above_uv <= 1'b0; supply_above_low_battery_level <= 1'b0;
    wt(12); supply_above_uv <= 1'b1;
    wt(4); supply_above_low_battery_level <= 1'b1;
  endtask : dip
  ////////////////////////////////////////
  task t_boot;
    @(posedge clk_sys);
    turn_on_event <= 1'b1; alive <= 1'b0;
    wait_sys(1'b1);
    turn_on_event <= 1'b0;
    chk(cpu_reset_n, 1'b1);
    rd_state(PMC_WDOG);
    wt(8); rd_state(PMC_WDOG);
    alive <= 1'b1;
    wt(90); rd_state(PMC_ON);
    $display("boot done");
  endtask : t_boot
  task t_keep;
    apb(1'b1, REG_CTRL, 32'h4);
    @(posedge clk_sys) alive <= 1'b0;
    wait_sys(1'b0);
    alive <= 1'b1;
    wait_sys(1'b1); rd_state(PMC_WDOG);
    wt(90); apb(1'b1, REG_CTRL, 32'h0);
    @(posedge clk_sys) alive <= 1'b0;
    wait_sys(1'b0); wt(80); chk(system_reset_n, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0); chk(err, 1'b1);
    chk(rdat, 32'h0);
    $display("keepalive done");
  endtask : t_keep
  task t_warm;
    apb(1'b1, REG_BUCK, 32'h1100); apb(1'b1, REG_CTRL, 32'h63);
    rd_state(PMC_UOWAIT);
    @(posedge clk_sys) alive <= 1'b0;
    wait_sys(1'b0); wt(3); chk(cpu_reset_n, 1'b1);
    chk(buck_enable, 5'h11);
    clk_scan(); chk(po, 1'b0);
    chk(co, 1'b1);
    @(posedge clk_sys) turn_on_event <= 1'b1;
    alive <= 1'b1;
    wt(6); chk(cpu_reset_n, 1'b1);
    chk(buck_enable & 5'h11, 5'h11);
    wait_sys(1'b1); turn_on_event <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0); chk(rdat[9], 1'b1);
    chk(rdat[3:0], PMC_WDOG);
    chk(int_out, 1'b1);
    apb(1'b0, REG_CTRL, 32'h0); chk(rdat, 32'h0);
    wt(90); $display("warm start done");
  endtask : t_warm
  task t_mem;
    apb(1'b1, REG_BUCK, 32'h10); apb(1'b1, REG_CTRL, 32'h1);
    wait_sys(1'b0); wt(3); chk(cpu_reset_n, 1'b0);
    chk(buck_enable, 5'h10);
    clk_scan(); chk(po | co, 1'b0);
    @(posedge clk_sys) turn_on_event <= 1'b1;
    wt(6); chk(buck_enable[4], 1'b1);
    wait_sys(1'b1); turn_on_event <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0); chk(rdat[8], 1'b1);
    apb(1'b0, REG_BUCK, 32'h0); chk(rdat, 32'h0);
    wt(90); $display("memory hold done");
  endtask : t_mem
  task t_power_cut;
    apb(1'b1, REG_POWER_CUT, 32'hF01); apb(1'b1, REG_CTRL, 32'h118);
    @(posedge clk_sys) sd_seen <= 1'b0;
    supply_above_uv <= 1'b0; supply_above_low_battery_level <= 1'b0;
    wt(40); chk(sd_seen, 1'b1);
    supply_above_uv <= 1'b1; supply_above_low_battery_level <= 1'b1;
    t_boot();
    apb(1'b0, REG_CTRL, 32'h0); chk(rdat[8], 1'b0);
    apb(1'b0, REG_POWER_CUT, 32'h0); chk(rdat, 32'h1F01);
    apb(1'b0, REG_STATUS, 32'h0); chk(rdat[10], 1'b0);
    apb(1'b1, REG_POWER_CUT, 32'hF10); apb(1'b1, REG_CTRL, 32'h118);
    dip(); wait_sys(1'b1); chk(sd_seen, 1'b0);
    apb(1'b0, REG_CTRL, 32'h0); chk(rdat[8], 1'b1);
    apb(1'b0, REG_POWER_CUT, 32'h0); chk(rdat, 32'h1F10);
    apb(1'b0, REG_STATUS, 32'h0); chk(rdat[10], 1'b1);
    apb(1'b1, REG_POWER_CUT, 32'h1110); apb(1'b1, REG_CTRL, 32'h118);
    dip(); wt(200); chk(system_reset_n, 1'b0);
    chk(sd_seen, 1'b1);
    $display("power cut done");
  endtask : t_power_cut
  ////////////////////////////////////////
  initial begin
    wt(6);
    rst_b <= 1'b1;
    wt(2);
    t_boot();
    t_keep();
    t_boot();
    t_warm();
    t_mem();
    t_power_cut();
    summarize();
  end
endmodule : tb
